// ### svd_params.svh
// Constants for the service request descriptor decoder
`ifndef SVD_PARAMS_SVH
`define SVD_PARAMS_SVH

`define SVD_WORD_W        32
`define SVD_NUM_WORDS     4
`define SVD_IDX_W         2
`define SVD_LAST_IDX      2'h3
`define SVD_LAST_USED_IDX 2'h2
`define SVD_OPC_HI        31
`define SVD_OPC_LO        27
`define SVD_ACKIE_BIT     26
`define SVD_ADDRESS_INCREMENT_DISABLE_BIT    18
`define SVD_BE_HI         17
`define SVD_BE_LO         14
`define SVD_LEN_HI        13
`define SVD_LEN_LO        0
`define SVD_LEN_W         14
`define SVD_CNT_W         15
`define SVD_LEN_MAX       15'h4000
`define SVD_CNT_ONE       15'h0001
`define SVD_SMP_LO        2
`define SVD_ALIGN_ZERO    2'h0
`define SVD_CFGA_HI       23
`define SVD_CFGA_LO       2
`define SVD_CFGA_W        22
`define SVD_CHAN_HI       10
`define SVD_CHAN_LO       0
`define SVD_CHAN_W        11
`define SVD_DIR_BIT       11
`define SVD_BE_W          4
`define SVD_SMEM_STEP     32'h0000_0004
`define SVD_CFG_STEP      22'h00_0001
`define SVD_XBUS_STEP     32'h0000_0001
`define SVD_IRQ_W         2
`define SVD_IRQ_ACK       0
`define SVD_IRQ_BADOP     1
`define SVD_CTRL_EN_BIT   0
`define SVD_REG_STATUS    8'h00
`define SVD_REG_CLEAR     8'h04
`define SVD_REG_IEN       8'h08
`define SVD_REG_CTRL      8'h0C
`define SVD_REG_STATE     8'h10

`endif

// ### svd_pkg.sv
// Types shared by the descriptor decoder files
`include "svd_params.svh"

package svd_pkg;

    typedef enum logic [4:0] {
        SVD_OPC_NO_OPERATION  = 5'h00,
        SVD_OPC_CFG_WRITE     = 5'h01,
        SVD_OPC_CFG_READ      = 5'h02,
        SVD_OPC_CHAN_ACTIVATE = 5'h03,
        SVD_OPC_CHAN_DEACT    = 5'h04,
        SVD_OPC_XBUS_WRITE    = 5'h06,
        SVD_OPC_XBUS_READ     = 5'h07
    } svd_opc_t;

    typedef enum logic [2:0] {
        SVD_ST_IDLE   = 3'h0,
        SVD_ST_LOAD   = 3'h1,
        SVD_ST_DECODE = 3'h2,
        SVD_ST_SRC    = 3'h3,
        SVD_ST_DST    = 3'h4,
        SVD_ST_CHAN   = 3'h5,
        SVD_ST_DONE   = 3'h6
    } svd_state_t;

    typedef enum logic [1:0] {
        SVD_TGT_SMEM = 2'h0,
        SVD_TGT_CFG  = 2'h1,
        SVD_TGT_XBUS = 2'h2
    } svd_tgt_t;

    typedef struct packed {
        svd_state_t              st;
        logic [`SVD_IDX_W-1:0]   widx;
        logic [`SVD_IDX_W-1:0]   ridx;
        logic                    rpend;
        logic [`SVD_WORD_W-1:0]  w0;
        logic [`SVD_WORD_W-1:0]  w1;
        logic [`SVD_WORD_W-1:0]  w2;
        svd_tgt_t                src;
        svd_tgt_t                dst;
        logic [`SVD_CNT_W-1:0]   cnt;
        logic [`SVD_WORD_W-1:0]  smem_addr;
        logic [`SVD_CFGA_W-1:0]  cfg_addr;
        logic [`SVD_WORD_W-1:0]  xbus_addr;
        logic [`SVD_WORD_W-1:0]  data;
        logic                    ackie;
        logic                    address_increment_disable;
        logic [`SVD_BE_W-1:0]    be;
        logic [4:0]              opcode;
        logic                    chan_cmd;
        logic                    chan_act;
        logic                    chan_tx;
        logic [`SVD_CHAN_W-1:0]  chan_num;
        logic                    ack_pulse;
        logic [`SVD_IRQ_W-1:0]   stat;
        logic [`SVD_IRQ_W-1:0]   ien;
        logic                    enable;
        logic [`SVD_WORD_W-1:0]  rdata;
    } svd_regs_t;

endpackage

// ### svd_word_mem.sv
// Small descriptor word store with registered read data
`timescale 1ns/1ps
`include "svd_params.svh"

module svd_word_mem
    import svd_pkg::*;
#(
    parameter int DEPTH = `SVD_NUM_WORDS,
    parameter int WIDTH = `SVD_WORD_W
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data_q
);

    logic [WIDTH-1:0] mem_q [DEPTH];

    generate
        if (DEPTH < 2)
        begin : g_bad_depth
            $error("svd_word_mem depth must be at least two");
        end
    endgenerate

    // Storage and registered read
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem_q[wr_addr] <= wr_data;
        end
        if (srst)
        begin
            rd_data_q <= '0;
        end
        else
        begin
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule

// ### svd_decoder.sv
// Service request descriptor decoder and request sequencer
`timescale 1ns/1ps
`include "svd_params.svh"

module svd_decoder
    import svd_pkg::*;
#(
    parameter int REG_AW = 8
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Register port
    input  wire logic [REG_AW-1:0]        reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    output logic                          irq,
    // Descriptor word stream
    input  wire logic                     rec_valid,
    input  wire logic [`SVD_WORD_W-1:0]   rec_word,
    output logic                          rec_ready,
    // Shared memory access
    output logic                          smem_req,
    output logic                          smem_we,
    output logic      [`SVD_WORD_W-1:0]   smem_addr,
    output logic      [`SVD_WORD_W-1:0]   smem_wdata,
    input  wire logic                     smem_ack,
    input  wire logic [`SVD_WORD_W-1:0]   smem_rdata,
    // Internal register access
    output logic                          cfg_req,
    output logic                          cfg_we,
    output logic      [`SVD_CFGA_W-1:0]   cfg_addr,
    output logic      [`SVD_WORD_W-1:0]   cfg_wdata,
    input  wire logic                     cfg_ack,
    input  wire logic [`SVD_WORD_W-1:0]   cfg_rdata,
    // Expansion bus access
    output logic                          xbus_req,
    output logic                          xbus_we,
    output logic      [`SVD_WORD_W-1:0]   xbus_addr,
    output logic      [`SVD_BE_W-1:0]     xbus_be,
    output logic      [`SVD_WORD_W-1:0]   xbus_wdata,
    input  wire logic                     xbus_ack,
    input  wire logic [`SVD_WORD_W-1:0]   xbus_rdata,
    // Channel control
    output logic                          chan_cmd,
    output logic                          chan_activate,
    output logic                          chan_tx,
    output logic      [`SVD_CHAN_W-1:0]   chan_num,
    output logic                          chan_abort,
    input  wire logic                     chan_is_active,
    // Completion
    output logic                          service_acknowledge,
    output logic                          busy
);

    svd_regs_t q;
    svd_regs_t d;
    logic [`SVD_WORD_W-1:0] mem_rd_data;
    logic                   mem_wr;
    logic                   src_ack;
    logic                   dst_ack;
    logic [`SVD_WORD_W-1:0] src_data;
    logic [`SVD_IRQ_W-1:0]  ev_set;
    svd_opc_t               opc;

    generate
        if (REG_AW < 5)
        begin : g_bad_aw
            $error("svd_decoder register address must be at least 5 bits");
        end
    endgenerate

    // Request line of one target in a transfer phase
    function automatic logic tgt_hit(input svd_state_t st, input svd_tgt_t s,
                                     input svd_tgt_t dd, input svd_tgt_t t);
        tgt_hit = (st == SVD_ST_SRC && s == t) || (st == SVD_ST_DST && dd == t);
    endfunction

    // Dword count from a 14-bit length field, zero meaning the maximum
    function automatic logic [`SVD_CNT_W-1:0] len_dwords(input logic [`SVD_WORD_W-1:0] w);
        logic [`SVD_LEN_W-1:0] l;
        l = w[`SVD_LEN_HI:`SVD_LEN_LO];
        len_dwords = (l == '0) ? `SVD_LEN_MAX : {1'b0, l};
    endfunction

    // Descriptor word store
    svd_word_mem #(
        .DEPTH (`SVD_NUM_WORDS),
        .WIDTH (`SVD_WORD_W)
    ) u_words (
        .clk       (clk),
        .srst      (srst),
        .wr_en     (mem_wr),
        .wr_addr   (q.widx),
        .wr_data   (rec_word),
        .rd_addr   (q.ridx),
        .rd_data_q (mem_rd_data)
    );

    // Handshake terms
    assign rec_ready = (q.st == SVD_ST_IDLE) && q.enable;
    assign mem_wr    = rec_valid && rec_ready;
    assign smem_req  = tgt_hit(q.st, q.src, q.dst, SVD_TGT_SMEM);
    assign cfg_req   = tgt_hit(q.st, q.src, q.dst, SVD_TGT_CFG);
    assign xbus_req  = tgt_hit(q.st, q.src, q.dst, SVD_TGT_XBUS);
    assign smem_we   = (q.st == SVD_ST_DST) && (q.dst == SVD_TGT_SMEM);
    assign cfg_we    = (q.st == SVD_ST_DST) && (q.dst == SVD_TGT_CFG);
    assign xbus_we   = (q.st == SVD_ST_DST) && (q.dst == SVD_TGT_XBUS);
    assign opc       = svd_opc_t'(q.w0[`SVD_OPC_HI:`SVD_OPC_LO]);

    // Acknowledge and data of the selected source or sink
    always_comb
    begin
        case (q.src)
            SVD_TGT_SMEM: begin src_ack = smem_ack; src_data = smem_rdata; end
            SVD_TGT_CFG:  begin src_ack = cfg_ack;  src_data = cfg_rdata;  end
            SVD_TGT_XBUS: begin src_ack = xbus_ack; src_data = xbus_rdata; end
            default:      begin src_ack = 1'b0;     src_data = '0;         end
        endcase
        case (q.dst)
            SVD_TGT_SMEM: dst_ack = smem_ack;
            SVD_TGT_CFG:  dst_ack = cfg_ack;
            SVD_TGT_XBUS: dst_ack = xbus_ack;
            default:      dst_ack = 1'b0;
        endcase
    end

    // Outputs from the state register; chan_abort is also gated by the chan_is_active input
    assign reg_rdata           = q.rdata;
    assign irq                 = |(q.stat & q.ien);
    assign smem_addr           = q.smem_addr;
    assign smem_wdata          = q.data;
    assign cfg_addr            = q.cfg_addr;
    assign cfg_wdata           = q.data;
    assign xbus_addr           = q.xbus_addr;
    assign xbus_be             = q.be;
    assign xbus_wdata          = q.data;
    assign chan_cmd            = q.chan_cmd;
    assign chan_activate       = q.chan_act;
    assign chan_tx             = q.chan_tx;
    assign chan_num            = q.chan_num;
    assign chan_abort          = q.chan_cmd && (!q.chan_act || chan_is_active);
    assign service_acknowledge = q.ack_pulse;
    assign busy                = q.st != SVD_ST_IDLE;

    // Next state of the whole block
    always_comb
    begin
        d           = q;
        ev_set      = '0;
        d.chan_cmd  = 1'b0;
        d.ack_pulse = 1'b0;
        case (q.st)
            SVD_ST_IDLE:
            begin
                if (mem_wr)
                begin
                    d.widx = q.widx + 2'h1;
                    if (q.widx == `SVD_LAST_IDX)
                    begin
                        d.st    = SVD_ST_LOAD;
                        d.ridx  = '0;
                        d.rpend = 1'b0;
                    end
                end
            end
            SVD_ST_LOAD:
            begin
                // Word 3 is reserved in every format and never read back
                d.rpend = 1'b1;
                d.ridx  = q.ridx + 2'h1;
                if (q.rpend)
                begin
                    case (q.ridx - 2'h1)
                        2'h0:    d.w0 = mem_rd_data;
                        2'h1:    d.w1 = mem_rd_data;
                        default: d.w2 = mem_rd_data;
                    endcase
                    if ((q.ridx - 2'h1) == `SVD_LAST_USED_IDX)
                    begin
                        d.st = SVD_ST_DECODE;
                    end
                end
            end
            SVD_ST_DECODE:
            begin
                d.ackie     = q.w0[`SVD_ACKIE_BIT];
                d.opcode    = q.w0[`SVD_OPC_HI:`SVD_OPC_LO];
                d.cnt       = len_dwords(q.w0);
                d.smem_addr = {q.w1[`SVD_WORD_W-1:`SVD_SMP_LO], `SVD_ALIGN_ZERO};
                d.cfg_addr  = q.w2[`SVD_CFGA_HI:`SVD_CFGA_LO];
                d.xbus_addr = q.w2;
                d.be        = q.w0[`SVD_BE_HI:`SVD_BE_LO];
                d.address_increment_disable    = q.w0[`SVD_ADDRESS_INCREMENT_DISABLE_BIT];
                d.chan_act  = opc == SVD_OPC_CHAN_ACTIVATE;
                d.chan_tx   = q.w0[`SVD_DIR_BIT];
                d.chan_num  = q.w0[`SVD_CHAN_HI:`SVD_CHAN_LO];
                case (opc)
                    SVD_OPC_CFG_WRITE:
                    begin
                        d.src = SVD_TGT_SMEM;
                        d.dst = SVD_TGT_CFG;
                        d.st  = SVD_ST_SRC;
                    end
                    SVD_OPC_CFG_READ:
                    begin
                        d.src = SVD_TGT_CFG;
                        d.dst = SVD_TGT_SMEM;
                        d.st  = SVD_ST_SRC;
                    end
                    SVD_OPC_XBUS_WRITE:
                    begin
                        d.src = SVD_TGT_SMEM;
                        d.dst = SVD_TGT_XBUS;
                        d.st  = SVD_ST_SRC;
                    end
                    SVD_OPC_XBUS_READ:
                    begin
                        d.src = SVD_TGT_XBUS;
                        d.dst = SVD_TGT_SMEM;
                        d.st  = SVD_ST_SRC;
                    end
                    SVD_OPC_CHAN_ACTIVATE, SVD_OPC_CHAN_DEACT:
                    begin
                        d.chan_cmd = 1'b1;
                        d.st       = SVD_ST_CHAN;
                    end
                    SVD_OPC_NO_OPERATION:
                    begin
                        d.st = SVD_ST_DONE;
                    end
                    default:
                    begin
                        // Reserved code: no action, no acknowledge
                        d.ackie                = 1'b0;
                        ev_set[`SVD_IRQ_BADOP] = 1'b1;
                        d.st                   = SVD_ST_DONE;
                    end
                endcase
            end
            SVD_ST_SRC:
            begin
                if (src_ack)
                begin
                    d.data = src_data;
                    d.st   = SVD_ST_DST;
                end
            end
            SVD_ST_DST:
            begin
                if (dst_ack)
                begin
                    d.cnt       = q.cnt - `SVD_CNT_ONE;
                    d.smem_addr = q.smem_addr + `SVD_SMEM_STEP;
                    d.cfg_addr  = q.cfg_addr + `SVD_CFG_STEP;
                    if (!q.address_increment_disable)
                    begin
                        d.xbus_addr = q.xbus_addr + `SVD_XBUS_STEP;
                    end
                    d.st = (q.cnt == `SVD_CNT_ONE) ? SVD_ST_DONE : SVD_ST_SRC;
                end
            end
            SVD_ST_CHAN:
            begin
                d.st = SVD_ST_DONE;
            end
            SVD_ST_DONE:
            begin
                d.ack_pulse          = q.ackie;
                ev_set[`SVD_IRQ_ACK] = q.ackie;
                d.st                 = SVD_ST_IDLE;
                d.widx               = '0;
            end
            default:
            begin
                d.st = SVD_ST_IDLE;
            end
        endcase

        // Register port: sticky status, set wins over clear
        d.rdata = '0;
        if (reg_wr && reg_addr == REG_AW'(`SVD_REG_CLEAR))
        begin
            d.stat = q.stat & ~reg_wdata[`SVD_IRQ_W-1:0];
        end
        d.stat = d.stat | ev_set;
        if (reg_wr && reg_addr == REG_AW'(`SVD_REG_IEN))
        begin
            d.ien = reg_wdata[`SVD_IRQ_W-1:0];
        end
        if (reg_wr && reg_addr == REG_AW'(`SVD_REG_CTRL))
        begin
            d.enable = reg_wdata[`SVD_CTRL_EN_BIT];
        end
        if (reg_rd)
        begin
            case (reg_addr)
                REG_AW'(`SVD_REG_STATUS): d.rdata = {30'h0, q.stat};
                REG_AW'(`SVD_REG_IEN):    d.rdata = {30'h0, q.ien};
                REG_AW'(`SVD_REG_CTRL):   d.rdata = {31'h0, q.enable};
                REG_AW'(`SVD_REG_STATE):  d.rdata = {9'h0, q.cnt, q.opcode, q.st};
                default:                  d.rdata = '0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_src_beat;
        q.st == SVD_ST_SRC && src_ack;
    endsequence

    sequence s_dst_beat;
        q.st == SVD_ST_DST && dst_ack;
    endsequence

    property p_four_words;
        (q.st == SVD_ST_IDLE) ##1 (q.st == SVD_ST_LOAD) |-> $past(q.widx) == `SVD_LAST_IDX && $past(mem_wr);
    endproperty
    a_four_words: assert property (p_four_words) else $error("decode began before four words");

    property p_ack_on;
        q.st == SVD_ST_DONE && q.ackie |=> service_acknowledge ##1 !service_acknowledge;
    endproperty
    a_ack_on: assert property (p_ack_on) else $error("acknowledge missing or too long");

    property p_ack_off;
        q.st == SVD_ST_DONE && !q.ackie |=> !service_acknowledge && !q.stat[`SVD_IRQ_ACK] || $past(q.stat[`SVD_IRQ_ACK]);
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("acknowledge raised though disabled");

    property p_len_zero;
        q.st == SVD_ST_DECODE && q.w0[`SVD_LEN_HI:`SVD_LEN_LO] == '0 |=> q.cnt == `SVD_LEN_MAX;
    endproperty
    a_len_zero: assert property (p_len_zero) else $error("zero length not taken as maximum");

    property p_ptrs;
        q.st == SVD_ST_DECODE |=> q.smem_addr[`SVD_SMP_LO-1:0] == `SVD_ALIGN_ZERO
            && q.smem_addr[`SVD_WORD_W-1:`SVD_SMP_LO] == $past(q.w1[`SVD_WORD_W-1:`SVD_SMP_LO])
            && q.cfg_addr == $past(q.w2[`SVD_CFGA_HI:`SVD_CFGA_LO]) && q.xbus_addr == $past(q.w2);
    endproperty
    a_ptrs: assert property (p_ptrs) else $error("pointer fields decoded wrongly");

    property p_copy;
        s_src_beat ##1 (q.st == SVD_ST_DST) |-> q.data == $past(src_data) && (smem_we || cfg_we || xbus_we);
    endproperty
    a_copy: assert property (p_copy) else $error("copied word differs from source");

    property p_reserved;
        q.st == SVD_ST_DECODE && opc inside {5'h05, [5'h08:5'h1F]} |=> q.st == SVD_ST_DONE
            ##1 q.stat[`SVD_IRQ_BADOP] && !service_acknowledge;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved command not refused");

    property p_lanes;
        xbus_req |-> xbus_be == q.w0[`SVD_BE_HI:`SVD_BE_LO];
    endproperty
    a_lanes: assert property (p_lanes) else $error("byte lanes differ from record");

    property p_incr;
        s_dst_beat ##0 (q.dst == SVD_TGT_XBUS || q.src == SVD_TGT_XBUS) |=>
            q.xbus_addr == $past(q.xbus_addr) + ($past(q.address_increment_disable) ? 32'h0 : `SVD_XBUS_STEP);
    endproperty
    a_incr: assert property (p_incr) else $error("bus address step wrong");

    property p_chan;
        chan_cmd |-> chan_num == q.w0[`SVD_CHAN_HI:`SVD_CHAN_LO] && chan_tx == q.w0[`SVD_DIR_BIT]
            && (chan_activate || chan_abort);
    endproperty
    a_chan: assert property (p_chan) else $error("channel command fields wrong");

endmodule

// ### svd_host_model.sv
// Host side responder for shared memory, internal registers and expansion bus
`timescale 1ns/1ps
`include "svd_params.svh"

module svd_host_model
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     srst,
    // Requests from the decoder
    input  wire logic                     smem_req,
    input  wire logic [`SVD_WORD_W-1:0]   smem_addr,
    input  wire logic                     cfg_req,
    input  wire logic [`SVD_CFGA_W-1:0]   cfg_addr,
    input  wire logic                     xbus_req,
    input  wire logic [`SVD_WORD_W-1:0]   xbus_addr,
    // Answers
    output logic                          smem_ack,
    output logic      [`SVD_WORD_W-1:0]   smem_rdata,
    output logic                          cfg_ack,
    output logic      [`SVD_WORD_W-1:0]   cfg_rdata,
    output logic                          xbus_ack,
    output logic      [`SVD_WORD_W-1:0]   xbus_rdata
);
    // One wait cycle before every acknowledge
    always_ff @(posedge clk)
    begin
        smem_ack <= !srst && smem_req && !smem_ack;
        cfg_ack  <= !srst && cfg_req && !cfg_ack;
        xbus_ack <= !srst && xbus_req && !xbus_ack;
    end
    // Data follow the address; shared memory data are inverted in the acknowledge cycle, the others outside it
    assign smem_rdata = ~smem_addr ^ {32{!smem_ack}};
    assign cfg_rdata  = ({10'h000, cfg_addr} ^ 32'h5A00_0000) ^ {32{!cfg_ack}};
    assign xbus_rdata = (xbus_addr + 32'h0F00_0000) ^ {32{!xbus_ack}};
endmodule

// ### tb_top.sv
// Self-checking bench for the descriptor decoder
`timescale 1ns/1ps
`include "svd_params.svh"

module tb_top
    import svd_pkg::*;
;
    logic clk, srst, reg_wr, reg_rd, irq, rec_valid, rec_ready, smem_req, smem_we, smem_ack, cfg_req, cfg_we;
    logic cfg_ack, xbus_req, xbus_we, xbus_ack, chan_cmd, chan_activate, chan_tx, chan_abort, chan_is_active;
    logic service_acknowledge, busy;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rec_word, smem_addr, smem_wdata, smem_rdata, cfg_wdata, cfg_rdata;
    logic [31:0] xbus_addr, xbus_wdata, xbus_rdata;
    logic [21:0] cfg_addr;
    logic [3:0]  xbus_be, be_l;
    logic [10:0] chan_num;
    logic [13:0] chl;
    logic [31:0] xa[$], ca[$], cd[$], sd[$], xd[$];
    int          mismatches, samples_checked, acks;
    logic [31:0] cw [3] = '{32'h1800_0923, 32'h1800_07FF, 32'h2000_0001};
    logic [13:0] ce [3] = '{14'h3923, 14'h17FF, 14'h2001};
    logic [4:0]  ro [3] = '{5'h05, 5'h08, 5'h1F};
    localparam logic [2:0] ACT_TAB = 3'b101;

    // Design and host model
    svd_decoder i_svd_decoder (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .rec_valid, .rec_word, .rec_ready, .smem_req, .smem_we, .smem_addr, .smem_wdata, .smem_ack, .smem_rdata,
        .cfg_req, .cfg_we, .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_rdata, .xbus_req, .xbus_we, .xbus_addr, .xbus_be,
        .xbus_wdata, .xbus_ack, .xbus_rdata, .chan_cmd, .chan_activate, .chan_tx, .chan_num, .chan_abort,
        .chan_is_active, .service_acknowledge, .busy);
    svd_host_model i_svd_host_model (.clk, .srst, .smem_req, .smem_addr, .cfg_req, .cfg_addr, .xbus_req,
        .xbus_addr, .smem_ack, .smem_rdata, .cfg_ack, .cfg_rdata, .xbus_ack, .xbus_rdata);

    // Clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Log of completed accesses and pulses
    always @(posedge clk)
    begin
        if (xbus_req && xbus_ack) xa.push_back(xbus_addr);
        if (xbus_req && xbus_ack) be_l <= xbus_be;
        if (cfg_req && cfg_ack && cfg_we) ca.push_back({10'h000, cfg_addr});
        if (cfg_req && cfg_ack && cfg_we) cd.push_back(cfg_wdata);
        if (smem_req && smem_ack && smem_we) sd.push_back(smem_wdata);
        if (xbus_req && xbus_ack && xbus_we) xd.push_back(xbus_wdata);
        if (service_acknowledge) acks++;
        if (chan_cmd) chl <= {chan_abort, chan_activate, chan_tx, chan_num};
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, e);
        @(posedge clk);
    endtask
    task automatic send(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
        logic [31:0] w [4];
        int n;
        w = '{w0, w1, w2, 32'h0};
        xa.delete(); ca.delete(); cd.delete(); sd.delete(); xd.delete(); acks = 0;
        for (int i = 0; i < 4; i++)
        begin
            rec_valid <= 1'b1;
            rec_word <= w[i];
            @(posedge clk);
        end
        rec_valid <= 1'b0;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, busy}, 32'h0);
        repeat (2) @(posedge clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        #200000;
        mismatches++;
        results;
    end
    // Test sequence
    initial
    begin
        srst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
        rec_valid = 1'b0; rec_word = 32'h0; chan_is_active = 1'b0;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(`SVD_REG_IEN, 32'h0);
        rd(`SVD_REG_STATE, 32'h0);
        wr(`SVD_REG_CTRL, 32'h1);
        wr(`SVD_REG_IEN, 32'h3);
        rd(`SVD_REG_IEN, 32'h3);
        rd(8'h20, 32'h0);
        $display("test registers done");
        for (int a = 0; a < 2; a++)
        begin
            send({5'h00, a[0], 26'h0}, 32'h0, 32'h0);
            chk(acks, a);
        end
        rd(`SVD_REG_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`SVD_REG_CLEAR, 32'h3);
        chk({31'h0, irq}, 32'h0);
        $display("test acknowledge done");
        send({5'h01, 1'b0, 12'hFFF, 14'd2}, 32'h0000_0107, 32'hFF00_0043);
        chk(ca.size(), 2);
        chk(ca[0], 32'h10);
        chk(ca[1], 32'h11);
        chk(cd[0], ~32'h104);
        chk(cd[1], ~32'h108);
        send({5'h02, 1'b0, 12'h000, 14'd1}, 32'h0000_0200, 32'h0000_0080);
        chk(sd[0], 32'h5A00_0020);
        $display("test configuration done");
        for (int d = 0; d < 2; d++)
        begin
            send({5'h06, 1'b0, 7'h00, d[0], 4'h5, 14'd3}, 32'h0000_0300, 32'h0000_1003);
            chk(xa.size(), 3);
            chk(xa[2], 32'h1005 - 2 * d);
            chk({28'h0, be_l}, 32'h5);
            chk(xd[2], ~32'h0000_0308);
        end
        send({5'h07, 1'b1, 7'h00, 1'b0, 4'hF, 14'd1}, 32'h0000_0400, 32'h0000_2000);
        chk(sd[0], 32'h0F00_2000);
        chk(acks, 1);
        $display("test expansion bus done");
        for (int k = 0; k < 3; k++)
        begin
            chan_is_active <= ACT_TAB[k];
            send(cw[k], 32'h0, 32'h0);
            chk({18'h0, chl}, {18'h0, ce[k]});
        end
        $display("test channel done");
        for (int k = 0; k < 3; k++)
        begin
            wr(`SVD_REG_CLEAR, 32'h3);
            send({ro[k], 1'b1, 26'h0}, 32'h0, 32'h0);
            chk(acks, 0);
            rd(`SVD_REG_STATUS, 32'h2);
        end
        $display("test reserved done");
        // Zero length copy starts at the maximum count; a reset then aborts it
        for (int i = 0; i < 4; i++)
        begin
            rec_valid <= 1'b1;
            rec_word <= (i == 0) ? 32'h0800_0000 : 32'h0;
            @(posedge clk);
        end
        rec_valid <= 1'b0;
        repeat (8) @(posedge clk);
        rd(`SVD_REG_STATE, 32'h0040_000C);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk({31'h0, busy}, 32'h0);
        rd(`SVD_REG_STATE, 32'h0);
        $display("test zero length done");
        results;
    end
endmodule
